// ===== verilog/adcspd_pkg.sv
/*
 Shared constants and types for the standby and power-down sequencer.
 Assumes a single 50 MHz clock; all pin timing is converted to cycles here.
*/
`default_nettype none

package adcspd_pkg;

    localparam longint CLK_PERIOD_NS = 64'h14;

    // times in their own unit (ns)
    localparam longint STBY_ACT_NS = 64'h4E20;
    localparam longint PD_PULSE_NS = 64'h7530;
    localparam longint PD_WAKE_NS = 64'h1F40;
    localparam longint SB_RDY_FAST_NS = 64'h3213D30;
    localparam longint SB_RDY_SLOW_NS = 64'h17F2FB40;

    localparam int CNT_W = 25;
    typedef logic [CNT_W-1:0] adcspd_cnt_t;

    // least time: round up, never below one cycle
    function automatic adcspd_cnt_t ns_to_cyc(input longint ns);
        longint c;
        c = (ns + CLK_PERIOD_NS - 64'h1) / CLK_PERIOD_NS;
        if (c < 64'h1) begin
            c = 64'h1;
        end
        return adcspd_cnt_t'(c);
    endfunction

    localparam adcspd_cnt_t STBY_ACT_CYC = ns_to_cyc(STBY_ACT_NS);
    localparam adcspd_cnt_t PD_PULSE_CYC = ns_to_cyc(PD_PULSE_NS);
    localparam adcspd_cnt_t PD_WAKE_CYC = ns_to_cyc(PD_WAKE_NS);
    localparam adcspd_cnt_t SB_RDY_FAST_CYC = ns_to_cyc(SB_RDY_FAST_NS);
    localparam adcspd_cnt_t SB_RDY_SLOW_CYC = ns_to_cyc(SB_RDY_SLOW_NS);

    localparam int DATA_W = 18;
    localparam int BITS_W = 5;
    typedef logic [BITS_W-1:0] adcspd_bits_t;
    localparam adcspd_bits_t DATA_BITS = 5'h12;
    localparam adcspd_bits_t SCLK_MAX = 5'h18;

    typedef struct packed {
        logic sclk;
        logic shutdown_n;
        logic speed;
    } adcspd_pins_s;

    localparam adcspd_pins_s PINS_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_PDOWN,
        ST_WAKE_PD,
        ST_RUN,
        ST_STBY,
        ST_WAKE_SB
    } adcspd_state_e;

endpackage

`default_nettype wire

// ===== verilog/adcspd_ctrl.sv
/*
 Standby and power-down sequencer of a pin-controlled delta-sigma converter,
 including the combined ready/serial-out pin and its shift-out.
 Assumes SCLK, SHUTDOWN_N and SPEED are asynchronous pins; CONV_VALID and
 CONV_DATA come from the converter core on CLK.
*/
// Operation
// - standby starts only after shift clock stays high 20 us.
// - after standby exit, new data ready after 52.51 ms or 401.8 ms.
// - shutdown low enters power-down; pulse lasts at least 30 us.
// - power-down resets all internal state.
// - power-down may abort a readback at any bit.
// - device resumes 8 us after shutdown returns high.
// - during standby the ready/data pin stays high while clock high.
// - leaving standby on clock low; first result afterwards is valid.
// - rate pin low selects slow rate, high fast; timing follows it.
`timescale 1ns/1ps
`default_nettype none

module adcspd_ctrl
    import adcspd_pkg::*;
#(
    parameter adcspd_cnt_t SB_RDY_FAST = SB_RDY_FAST_CYC,
    parameter adcspd_cnt_t SB_RDY_SLOW = SB_RDY_SLOW_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCLK,
    input wire logic SHUTDOWN_N,
    input wire logic SPEED,
    input wire logic CONV_VALID,
    input wire logic [DATA_W-1:0] CONV_DATA,
    output logic READY_AND_SERIAL_OUT,
    output logic ANALOG_EN,
    output logic CORE_RESET_N,
    output logic STANDBY,
    output logic POWERED_DOWN,
    output logic RATE_FAST
);

    adcspd_pins_s s1_ff, s2_ff, s3_ff, stable_ff, prev_ff;
    adcspd_pins_s nxt_s1, nxt_s2, nxt_s3, nxt_stable, nxt_prev;

    // three-stage pin capture; accept a change once stages two and three agree
    always_comb begin
        nxt_s1 = {SCLK, SHUTDOWN_N, SPEED};
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
        nxt_stable = ((s2_ff ~^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & stable_ff);
        nxt_prev = stable_ff;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s1_ff <= PINS_RST;
            s2_ff <= PINS_RST;
            s3_ff <= PINS_RST;
            stable_ff <= PINS_RST;
            prev_ff <= PINS_RST;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            stable_ff <= nxt_stable;
            prev_ff <= nxt_prev;
        end
    end

    logic sclk_rise;
    adcspd_cnt_t sb_rdy_cyc;
    assign sclk_rise = stable_ff.sclk & ~prev_ff.sclk;
    assign sb_rdy_cyc = stable_ff.speed ? SB_RDY_FAST : SB_RDY_SLOW;

    adcspd_state_e state_ff, nxt_state;
    adcspd_cnt_t cnt_ff, nxt_cnt;
    adcspd_bits_t bits_ff, nxt_bits;
    logic [DATA_W-1:0] shreg_ff, nxt_shreg;
    logic dout_ff, nxt_dout;
    logic armed_ff, nxt_armed;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_bits = bits_ff;
        nxt_shreg = shreg_ff;
        nxt_dout = dout_ff;
        nxt_armed = armed_ff;
        case (state_ff)
            ST_PDOWN: begin
                nxt_dout = 1'b1;
                // stay down a full pulse even if the pin comes back early
                if (cnt_ff < PD_PULSE_CYC) begin
                    nxt_cnt = cnt_ff + 1'b1;
                end else if (stable_ff.shutdown_n) begin
                    nxt_state = ST_WAKE_PD;
                    nxt_cnt = '0;
                end
            end
            ST_WAKE_PD: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= PD_WAKE_CYC - 1'b1) begin
                    nxt_state = ST_RUN;
                    nxt_cnt = '0;
                end
            end
            ST_RUN: begin
                if (sclk_rise && bits_ff < DATA_BITS) begin
                    nxt_dout = shreg_ff[DATA_W-1];
                    nxt_shreg = {shreg_ff[DATA_W-2:0], 1'b0};
                    nxt_bits = bits_ff + 1'b1;
                end else if (sclk_rise && bits_ff < SCLK_MAX) begin
                    nxt_dout = 1'b1;
                    nxt_bits = bits_ff + 1'b1;
                end
                // fresh result overwrites unread data
                if (CONV_VALID) begin
                    nxt_shreg = CONV_DATA;
                    nxt_dout = 1'b0;
                    nxt_bits = '0;
                    nxt_armed = 1'b1;
                end
                if (stable_ff.sclk && armed_ff) begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff >= STBY_ACT_CYC - 1'b1) begin
                        nxt_state = ST_STBY;
                        nxt_cnt = '0;
                        nxt_dout = 1'b1;
                        nxt_armed = 1'b0;
                        nxt_bits = '0;
                    end
                end else begin
                    nxt_cnt = '0;
                end
            end
            ST_STBY: begin
                nxt_dout = 1'b1;
                if (!stable_ff.sclk) begin
                    nxt_state = ST_WAKE_SB;
                    nxt_cnt = '0;
                end
            end
            ST_WAKE_SB: begin
                // core results while settling are dropped
                nxt_dout = 1'b1;
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= sb_rdy_cyc - 1'b1) begin
                    nxt_state = ST_RUN;
                    nxt_cnt = '0;
                    nxt_shreg = CONV_DATA;
                    nxt_dout = 1'b0;
                    nxt_bits = '0;
                    nxt_armed = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_PDOWN;
                nxt_cnt = '0;
            end
        endcase
        // shutdown aborts anything, including a half-read result
        if (!stable_ff.shutdown_n && state_ff != ST_PDOWN) begin
            nxt_state = ST_PDOWN;
            nxt_cnt = '0;
            nxt_bits = '0;
            nxt_shreg = '0;
            nxt_dout = 1'b1;
            nxt_armed = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_ff <= ST_PDOWN;
            cnt_ff <= '0;
            bits_ff <= '0;
            shreg_ff <= '0;
            dout_ff <= 1'b1;
            armed_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            bits_ff <= nxt_bits;
            shreg_ff <= nxt_shreg;
            dout_ff <= nxt_dout;
            armed_ff <= nxt_armed;
        end
    end

    assign READY_AND_SERIAL_OUT = dout_ff;
    assign ANALOG_EN = (state_ff == ST_RUN) || (state_ff == ST_WAKE_SB);
    assign CORE_RESET_N = (state_ff != ST_PDOWN) && (state_ff != ST_WAKE_PD);
    assign STANDBY = (state_ff == ST_STBY);
    assign POWERED_DOWN = (state_ff == ST_PDOWN);
    assign RATE_FAST = stable_ff.speed;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_stby_entry;
        state_ff == ST_RUN ##1 state_ff == ST_STBY;
    endsequence

    property p_stby_min_high;
        s_stby_entry |-> $past(cnt_ff) == STBY_ACT_CYC - 1'b1 && $past(stable_ff.sclk);
    endproperty
    a_stby_min_high: assert property (p_stby_min_high) else $error("standby entered early");

    property p_stby_pin_high;
        state_ff == ST_STBY |-> READY_AND_SERIAL_OUT && !ANALOG_EN;
    endproperty
    a_stby_pin_high: assert property (p_stby_pin_high) else $error("pin low in standby");

    sequence s_sb_exit;
        state_ff == ST_WAKE_SB ##1 state_ff == ST_RUN;
    endsequence

    property p_sb_ready_lat;
        s_sb_exit |-> !READY_AND_SERIAL_OUT && $past(cnt_ff) == $past(sb_rdy_cyc) - 1'b1;
    endproperty
    a_sb_ready_lat: assert property (p_sb_ready_lat) else $error("bad ready latency after standby");

    property p_sb_rate;
        s_sb_exit |-> $past(cnt_ff) == ($past(stable_ff.speed) ? SB_RDY_FAST : SB_RDY_SLOW) - 1'b1;
    endproperty
    a_sb_rate: assert property (p_sb_rate) else $error("wake latency ignores rate pin");

    property p_sb_no_early;
        state_ff == ST_WAKE_SB |-> READY_AND_SERIAL_OUT;
    endproperty
    a_sb_no_early: assert property (p_sb_no_early) else $error("result during standby settling");

    property p_pd_min;
        state_ff == ST_PDOWN ##1 state_ff == ST_WAKE_PD |-> $past(cnt_ff) == PD_PULSE_CYC;
    endproperty
    a_pd_min: assert property (p_pd_min) else $error("power-down shorter than minimum");

    property p_pd_reset;
        !stable_ff.shutdown_n |=> POWERED_DOWN && !CORE_RESET_N && bits_ff == '0 && !armed_ff;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("state not cleared by power-down");

    property p_pd_abort;
        state_ff == ST_RUN && bits_ff != '0 && !stable_ff.shutdown_n |=> READY_AND_SERIAL_OUT ##1 POWERED_DOWN;
    endproperty
    a_pd_abort: assert property (p_pd_abort) else $error("readback not abandoned");

    property p_pd_wake;
        state_ff == ST_WAKE_PD ##1 state_ff == ST_RUN |-> $past(cnt_ff) == PD_WAKE_CYC - 1'b1 && CORE_RESET_N;
    endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("wake-up time wrong");

endmodule

`default_nettype wire

// ===== test/adcspd_host.sv
/*
 Host model: drives the shift clock and shutdown pins.
 Assumes its tasks are called just after a rising edge of CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module adcspd_host (
    input wire logic CLK,
    output logic SCLK,
    output logic SHUTDOWN_N
);
    initial begin
        SCLK = 1'b0;
        SHUTDOWN_N = 1'b0;
    end

    // supplies are up from time zero; release well after 10 us
    task automatic power_up();
        repeat (600) @(posedge CLK);
        SHUTDOWN_N <= 1'b1;
    endtask

    // shift clock is held n cycles as given, with no minimum
    task automatic hold_clk(input logic v, input int n);
        SCLK <= v;
        repeat (n) @(posedge CLK);
    endtask

    // low pulses never shorter than 30 us
    task automatic hold_pd(input logic v, input int n);
        int k;
        k = (!v && n < 1500) ? 1500 : n;
        SHUTDOWN_N <= v;
        repeat (k) @(posedge CLK);
    endtask
endmodule

`default_nettype wire

// ===== test/testbench.sv
/*
 Self-checking bench for the standby and power-down sequencer.
 Assumes the host model drives the clock and shutdown pins; expected bits come from a queue.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import adcspd_pkg::*;
    localparam int RDY_FAST = 50;
    localparam int RDY_SLOW = 80;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic speed = 1'b0;
    logic conv_valid = 1'b0;
    logic [DATA_W-1:0] conv_data = '0;
    logic sclk, shutdown_n, dout, analog_en, core_reset_n, standby, powered_down, rate_fast;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] lfsr = 32'h17614538;
    logic [DATA_W-1:0] exp_word;
    logic q[$];

    always #10 clk = ~clk;

    adcspd_host u_host (.CLK(clk), .SCLK(sclk), .SHUTDOWN_N(shutdown_n));

    adcspd_ctrl #(.SB_RDY_FAST(adcspd_cnt_t'(RDY_FAST)), .SB_RDY_SLOW(adcspd_cnt_t'(RDY_SLOW))) u_dut (
        .CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .SHUTDOWN_N(shutdown_n), .SPEED(speed),
        .CONV_VALID(conv_valid), .CONV_DATA(conv_data), .READY_AND_SERIAL_OUT(dout),
        .ANALOG_EN(analog_en), .CORE_RESET_N(core_reset_n), .STANDBY(standby),
        .POWERED_DOWN(powered_down), .RATE_FAST(rate_fast)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // new random core word, queued msb first
    task automatic next_word();
        lfsr = lfsr_next(lfsr);
        exp_word = lfsr[DATA_W-1:0];
        conv_data <= exp_word;
        q.delete();
        for (int i = DATA_W - 1; i >= 0; i--) begin
            q.push_back(exp_word[i]);
        end
    endtask

    task automatic load();
        next_word();
        conv_valid <= 1'b1;
        @(posedge clk);
        conv_valid <= 1'b0;
        @(negedge clk);
        check(dout, 1'b0);
        @(posedge clk);
    endtask

    task automatic read_bits(input int n);
        for (int i = 0; i < n; i++) begin
            u_host.hold_clk(1'b1, 8);
            u_host.hold_clk(1'b0, 8);
            @(negedge clk);
            check(dout, q.pop_front());
            @(posedge clk);
        end
    endtask

    initial begin
        int n;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check({powered_down, core_reset_n, dout}, 3'h5);
        @(posedge clk);
        u_host.power_up();
        repeat (1280) @(posedge clk);
        @(negedge clk);
        check(core_reset_n, 1'b0);
        repeat (30) @(posedge clk);
        @(negedge clk);
        check({core_reset_n, powered_down, rate_fast}, 3'h4);
        @(posedge clk);
        load();
        read_bits(DATA_W);
        // abandon a readback after five bits
        load();
        read_bits(5);
        u_host.hold_pd(1'b0, 1600);
        @(negedge clk);
        check({powered_down, core_reset_n, analog_en, dout}, 4'h9);
        @(posedge clk);
        u_host.hold_pd(1'b1, 390);
        @(negedge clk);
        check(core_reset_n, 1'b0);
        @(posedge clk);
        // no result since power-down, so a long high must not arm standby
        u_host.hold_clk(1'b1, 1040);
        @(negedge clk);
        check({core_reset_n, standby}, 2'h2);
        @(posedge clk);
        u_host.hold_clk(1'b0, 8);
        for (int sp = 1; sp >= 0; sp--) begin
            speed <= sp[0];
            load();
            u_host.hold_clk(1'b1, 995);
            @(negedge clk);
            check(standby, 1'b0);
            @(posedge clk);
            u_host.hold_clk(1'b1, 15);
            @(negedge clk);
            check({standby, analog_en, dout, rate_fast}, {3'b101, sp[0]});
            @(posedge clk);
            next_word();
            u_host.hold_clk(1'b0, (sp == 1 ? RDY_FAST : RDY_SLOW) - 2);
            @(negedge clk);
            check(dout, 1'b1);
            for (n = 0; n < 12 && dout !== 1'b0; n++) begin
                @(negedge clk);
            end
            check(32'(n < 12), 1'b1);
            @(posedge clk);
            read_bits(DATA_W);
        end
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule

`default_nettype wire
